// File: verilog/watchdog_pkg.sv
// constants shared by the watchdog timer design
package watchdog_pkg;

  // ****************************************
  // i/o addresses
  // ****************************************
  localparam logic [7:0] MASTER_CONTROL_ADDR = 8'hF0;
  localparam logic [7:0] COMMAND_KEY_ADDR    = 8'hF1;

  // ****************************************
  // master control field positions
  // ****************************************
  localparam int ENABLE_BIT_POS   = 7;
  localparam int PERIOD_FIELD_HI  = 6;
  localparam int PERIOD_FIELD_LO  = 5;
  localparam int EXT_RESET_POS    = 4;
  localparam int RESERVED_HI      = 3;
  localparam int RESERVED_LO      = 0;

  // ****************************************
  // reset values and fixed read values
  // ****************************************
  localparam logic       ENABLE_RESET     = 1'b1;
  localparam logic [1:0] PERIOD_RESET     = 2'b11;
  localparam logic       EXT_RESET_RESET  = 1'b1;
  localparam logic [3:0] RESERVED_READ    = 4'h3;
  localparam logic [7:0] WRITE_ONLY_READ  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // ****************************************
  // command key codes
  // ****************************************
  localparam logic [7:0] KEY_DISABLE      = 8'hB1;
  localparam logic [7:0] KEY_CLEAR        = 8'h4E;

  // ****************************************
  // timing counts, in system clock periods
  // ****************************************
  localparam int         COUNT_WIDTH      = 22;
  localparam int         PERIOD_EXP_BASE  = 16;
  localparam int         PERIOD_EXP_STEP  = 2;
  localparam int         PULSE_WIDTH      = 5;
  localparam logic [4:0] RESET_PULSE_CYCLES = 5'h10;

endpackage

// File: verilog/timeout_counter.sv
// free-running timeout counter with selectable power-of-two period
`timescale 1ns/100ps
`default_nettype none

module timeout_counter
  import watchdog_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [1:0] period_sel,
  output var  logic       expired
);

  logic [COUNT_WIDTH-1:0] cnt_q;
  logic [COUNT_WIDTH-1:0] cnt_d;
  logic [COUNT_WIDTH-1:0] limit;
  logic                   expired_q;
  logic                   expired_d;
  logic [4:0]             exp_sel;

  // ****************************************
  // terminal count: period is 2^(16 + 2*sel) clocks
  // ****************************************
  always_comb begin
    exp_sel = 5'(PERIOD_EXP_BASE) + 5'(PERIOD_EXP_STEP) * {3'h0, period_sel};
    limit   = COUNT_WIDTH'((32'h1 << exp_sel) - 32'h1);
  end

  always_comb begin
    cnt_d     = cnt_q;
    expired_d = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (run) begin
      // >= guards against a period shortened below the running count
      if (cnt_q >= limit) begin
        cnt_d     = '0;
        expired_d = 1'b1;
      end else begin
        cnt_d = cnt_q + COUNT_WIDTH'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q     <= '0;
      expired_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;

endmodule

`default_nettype wire

// File: verilog/watchdog_unit.sv
// watchdog timer: master control and command key registers, reset generation
//
// Summary of operation
// - timeout merges onto active-low reset pin function
// - reset default: timeout also drives reset pin
// - D4 one pulls pin; zero resets processor only
// - D7 set by reset; writing one enables
// - disable: clear D7, then write B1h key
// - single stray write never disables watchdog
// - writing 4Eh restarts watchdog count
// - D6-D5 select 2^16, 2^18, 2^20, 2^22 clocks
// - period field resets to 11, longest
// - low four bits read back 0011
// - command register is write-only
// - master at F0h, command key at F1h
// - halt-mode field ignored
`timescale 1ns/100ps
`default_nettype none

module watchdog_unit
  import watchdog_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr_stb,
  input  wire logic       io_rd_stb,
  input  wire logic [7:0] io_wdata,
  output var  logic [7:0] io_rdata,
  output var  logic       cpu_reset_req,
  output var  logic       reset_pin_out,
  output var  logic       reset_pin_oe_n
);

  // ****************************************
  // register state
  // ****************************************
  logic       enable_bit_q;
  logic       enable_bit_d;
  logic [1:0] period_q;
  logic [1:0] period_d;
  logic       ext_reset_q;
  logic       ext_reset_d;
  logic       run_q;
  logic       run_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic       master_wr;
  logic       key_wr;
  logic       clear_cmd;
  logic       expired;

  // ****************************************
  // address decode
  // ****************************************
  always_comb begin
    master_wr = io_wr_stb && (io_addr == MASTER_CONTROL_ADDR);
    key_wr    = io_wr_stb && (io_addr == COMMAND_KEY_ADDR);
    clear_cmd = key_wr && (io_wdata == KEY_CLEAR);
  end

  // ****************************************
  // master control and run state
  // ****************************************
  // the enable bit alone only arms the disable; the counter keeps running
  // until the key arrives, so one stray write cannot stop it
  always_comb begin
    enable_bit_d = enable_bit_q;
    period_d     = period_q;
    ext_reset_d  = ext_reset_q;
    run_d        = run_q;
    if (master_wr) begin
      // low nibble is reserved and dropped; no halt-mode bits are kept
      enable_bit_d = io_wdata[ENABLE_BIT_POS];
      period_d     = io_wdata[PERIOD_FIELD_HI:PERIOD_FIELD_LO];
      ext_reset_d  = io_wdata[EXT_RESET_POS];
      if (io_wdata[ENABLE_BIT_POS]) begin
        run_d = 1'b1;
      end
    end else if (key_wr && (io_wdata == KEY_DISABLE) && !enable_bit_q) begin
      run_d = 1'b0;
    end
    // any other key value, or B1h while enabled, leaves state alone
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_bit_q <= ENABLE_RESET;
      period_q     <= PERIOD_RESET;
      ext_reset_q  <= EXT_RESET_RESET;
      run_q        <= ENABLE_RESET;
    end else begin
      enable_bit_q <= enable_bit_d;
      period_q     <= period_d;
      ext_reset_q  <= ext_reset_d;
      run_q        <= run_d;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdata_d = rdata_q;
    if (io_rd_stb) begin
      if (io_addr == MASTER_CONTROL_ADDR) begin
        rdata_d = {enable_bit_q, period_q, ext_reset_q, RESERVED_READ};
      end else if (io_addr == COMMAND_KEY_ADDR) begin
        rdata_d = WRITE_ONLY_READ;
      end else begin
        rdata_d = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // timeout counter
  // ****************************************
  timeout_counter u_counter (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .run        (run_q),
    .clear      (clear_cmd),
    .period_sel (period_q),
    .expired    (expired)
  );

  // ****************************************
  // reset pulse generation
  // ****************************************
  // the mode bit is latched at expiry so a write during the pulse
  // cannot cut the pin drive short
  logic [PULSE_WIDTH-1:0] pulse_cnt_q;
  logic [PULSE_WIDTH-1:0] pulse_cnt_d;
  logic                   pulse_ext_q;
  logic                   pulse_ext_d;
  logic                   cpu_rst_q;
  logic                   cpu_rst_d;
  logic                   pin_oe_n_q;
  logic                   pin_oe_n_d;

  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    pulse_ext_d = pulse_ext_q;
    if (expired) begin
      pulse_cnt_d = RESET_PULSE_CYCLES;
      pulse_ext_d = ext_reset_q;
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_d = pulse_cnt_q - PULSE_WIDTH'(1);
    end
    // processor reset always follows a timeout; pin only in external mode
    cpu_rst_d  = (pulse_cnt_d != '0);
    pin_oe_n_d = !((pulse_cnt_d != '0) && pulse_ext_d);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_cnt_q <= '0;
      pulse_ext_q <= EXT_RESET_RESET;
      cpu_rst_q   <= 1'b0;
      pin_oe_n_q  <= 1'b1;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
      pulse_ext_q <= pulse_ext_d;
      cpu_rst_q   <= cpu_rst_d;
      pin_oe_n_q  <= pin_oe_n_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign io_rdata       = rdata_q;
  assign cpu_reset_req  = cpu_rst_q;
  assign reset_pin_oe_n = pin_oe_n_q;
  // open drain: only ever drives low
  assign reset_pin_out  = 1'b0;

endmodule

`default_nettype wire

// File: test/watchdog_unit_monitor.sv
// port-level assertions for the watchdog timer
`timescale 1ns/100ps
`default_nettype none

module watchdog_unit_monitor
  import watchdog_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [7:0] io_addr,
  input wire logic       io_wr_stb,
  input wire logic       io_rd_stb,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       cpu_reset_req,
  input wire logic       reset_pin_out,
  input wire logic       reset_pin_oe_n
);
  // ****************************************
  // pulse length helper and properties
  // ****************************************
  logic [5:0] hi_d;
  logic [5:0] hi_q;

  // a counter, since a 16-cycle repetition would be slow to unroll
  always_comb hi_d = cpu_reset_req ? hi_q + 6'h01 : 6'h00;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      hi_q <= 6'h00;
    else
      hi_q <= hi_d;
  end

  // shadow of the external-reset mode bit, rebuilt from bus writes
  logic ext_q;
  logic ext_d;

  always_comb begin
    ext_d = ext_q;
    if (io_wr_stb && io_addr == MASTER_CONTROL_ADDR)
      ext_d = io_wdata[EXT_RESET_POS];
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      ext_q <= EXT_RESET_RESET;
    else
      ext_q <= ext_d;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_pin_low; reset_pin_out == 1'h0; endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin data not low");
  property p_pin_req; !reset_pin_oe_n |-> cpu_reset_req; endproperty
  a_pin_req: assert property (p_pin_req) else $error("pin low without reset");
  property p_oe_with_req; $fell(reset_pin_oe_n) |-> $rose(cpu_reset_req); endproperty
  a_oe_with_req: assert property (p_oe_with_req) else $error("pin and reset apart");
  property p_pulse_len; $fell(cpu_reset_req) |-> hi_q == 6'h10; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length");
  property p_rdata_hold; !$past(io_rd_stb) |-> $stable(io_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_key_read; io_rd_stb && io_addr == COMMAND_KEY_ADDR |=> io_rdata == 8'h00; endproperty
  a_key_read: assert property (p_key_read) else $error("command read not zero");
  property p_rsvd;
    io_rd_stb && io_addr == MASTER_CONTROL_ADDR |=> io_rdata[3:0] == 4'h3;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
  property p_wr_rd;
    io_wr_stb && io_addr == MASTER_CONTROL_ADDR ##1 io_rd_stb && io_addr == MASTER_CONTROL_ADDR
      |=> io_rdata[7:4] == $past(io_wdata[7:4], 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("control readback wrong");
  // mode is taken at expiry, one edge before the request is seen to rise; this check samples the shadow two edges back
  property p_pin_mode; $rose(cpu_reset_req) |-> reset_pin_oe_n == !$past(ext_q, 2); endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin drive against mode");
endmodule

bind watchdog_unit watchdog_unit_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .io_addr(io_addr), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .cpu_reset_req(cpu_reset_req), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n(reset_pin_oe_n));
`default_nettype wire

// File: test/tb_watchdog_unit.sv
// self-checking testbench for the watchdog timer
`timescale 1ns/100ps
`default_nettype none

module tb_watchdog_unit;
  import watchdog_pkg::*;
  // ****************************************
  // stimulus, scoreboard and verdict
  // ****************************************
  logic       core_clk;
  logic       sys_rst;
  logic [7:0] io_addr;
  logic       io_wr_stb;
  logic       io_rd_stb;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       cpu_reset_req;
  logic       reset_pin_out;
  logic       reset_pin_oe_n;
  logic [7:0] exp_q[$];
  logic [31:0] v;
  int         errors = 0;
  int         checks_done = 0;
  int         seed = 32'h95E7;
  int         cyc = 0;
  int         c0;
  int         d;
  int         n;

  watchdog_unit u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .cpu_reset_req(cpu_reset_req), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // an idle edge after each strobe keeps the driver from assigning twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    io_addr <= a;
    io_wdata <= x;
    io_wr_stb <= 1'h1;
    @(posedge core_clk);
    io_wr_stb <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    io_addr <= a;
    io_rd_stb <= 1'h1;
    exp_q.push_back(e);
    @(posedge core_clk);
    io_rd_stb <= 1'h0;
    @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= cyc + 1;

  always @(posedge core_clk) begin
    if (io_rd_stb === 1'h1) begin
      @(negedge core_clk);
      chk(io_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    errors++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'h1;
    io_addr = 8'h00;
    io_wr_stb = 1'h0;
    io_rd_stb = 1'h0;
    io_wdata = 8'h00;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    rd(MASTER_CONTROL_ADDR, 8'hF3);
    rd(COMMAND_KEY_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(MASTER_CONTROL_ADDR, {1'h1, 2'(i), v[4], 4'h3});
      wr(8'hF2, v[15:8]);
      rd(MASTER_CONTROL_ADDR, {1'h1, 2'(i), v[4], 4'h3});
    end
    // write then read on the very next edge: readback must already show it
    io_addr   <= MASTER_CONTROL_ADDR;
    io_wdata  <= {1'h1, v[22:20], 4'h3};
    io_wr_stb <= 1'h1;
    @(posedge core_clk);
    io_wr_stb <= 1'h0;
    rd(MASTER_CONTROL_ADDR, {1'h1, v[22:20], 4'h3});
    wr(MASTER_CONTROL_ADDR, 8'h93);
    wr(COMMAND_KEY_ADDR, KEY_CLEAR);
    c0 = cyc;
    repeat (20000) @(posedge core_clk);
    wr(COMMAND_KEY_ADDR, KEY_DISABLE);
    wr(MASTER_CONTROL_ADDR, 8'h13);
    wr(COMMAND_KEY_ADDR, 8'h5A);
    wr(COMMAND_KEY_ADDR, KEY_DISABLE);
    d = cyc;
    rd(MASTER_CONTROL_ADDR, 8'h13);
    repeat (10000) @(posedge core_clk);
    wr(MASTER_CONTROL_ADDR, 8'h93);
    d = cyc - d;
    for (n = 0; n < 60000 && cpu_reset_req !== 1'h1; n++) @(negedge core_clk);
    // exact count, so a few lost cycles from an early stop show up; one edge of latency
    chk({7'h00, (cyc - c0 - d) == (1 << PERIOD_EXP_BASE) + 1}, 8'h01);
    chk({6'h00, cpu_reset_req, reset_pin_oe_n}, 8'h02);
    repeat (20) @(posedge core_clk);
    chk({6'h00, cpu_reset_req, reset_pin_oe_n}, 8'h01);
    sys_rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    rd(MASTER_CONTROL_ADDR, 8'hF3);
    give_verdict();
  end
endmodule
`default_nettype wire
